// *** core/lssr_asd.sv ***
`timescale 1ns/100ps
`include "lssr_defines.svh"
module lssr_spd_det #(
	parameter int SENSE_CYC = `LSSR_SENSE_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	lssr_det_if.det  dif
);
	import lssr_pkg::*;

	lssr_det_e   state;
	lssr_det_e   next_state;
	logic [7:0]  cnt;
	logic [7:0]  next_cnt;
	lssr_speed_t res;
	lssr_speed_t next_res;

	assign dif.result = res;
	assign dif.done   = (state == DET_DONE);

	// A start while a run is in progress is dropped; the run under way finishes.
	always_comb
	begin
		next_state = state;
		next_cnt   = cnt;
		next_res   = res;
		unique case (state)
			DET_IDLE:
			begin
				next_cnt = 8'h00;
				if (dif.start)
					next_state = DET_SENSE;
			end
			DET_SENSE:
			begin
				next_cnt = cnt + 8'h01;
				if (cnt == 8'(SENSE_CYC - 1))
				begin
					next_res   = dif.phy_speed;
					next_state = DET_DONE;
				end
			end
			DET_DONE:
				next_state = DET_IDLE;
		endcase
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			state <= DET_IDLE;
			cnt   <= 8'h00;
			res   <= `LSSR_SPD_10;
		end
		else
		begin
			state <= next_state;
			cnt   <= next_cnt;
			res   <= next_res;
		end
	end
endmodule : lssr_spd_det

// *** core/lssr_defines.svh ***
`ifndef LSSR_DEFINES_SVH
`define LSSR_DEFINES_SVH

`define LSSR_ADDR_W       8
`define LSSR_OFS_STATUS   8'h00
`define LSSR_OFS_CTRL     8'h04
`define LSSR_OFS_ISTAT    8'h08
`define LSSR_OFS_IMASK    8'h0C

`define LSSR_SPD_LSB      6
`define LSSR_SENSED_LSB   8
`define LSSR_PHYR_FLAG_BIT 10
`define LSSR_MACT_BIT     19

`define LSSR_C_FSPD_LSB   0
`define LSSR_C_FRC_BIT    2
`define LSSR_C_AUTO_BIT   3
`define LSSR_C_MDIS_BIT   4
`define LSSR_C_TRIG_BIT   5

`define LSSR_I_PHYR       0
`define LSSR_I_DET        1
`define LSSR_I_MSTOP      2
`define LSSR_IRQ_W        3

`define LSSR_PHYR_FLAG_RST 1'h1
`define LSSR_MACT_RST     1'h1
`define LSSR_SPD_10       2'h0
`define LSSR_SPD_100      2'h1
`define LSSR_SPD_1000     2'h2
`define LSSR_SPD_1000B    2'h3

`define LSSR_SENSE_CYC    8
`define LSSR_RESP_OKAY    2'h0
`define LSSR_RESP_SLVERR  2'h2

`endif

// *** core/lssr_det_if.sv ***
`timescale 1ns/100ps
interface lssr_det_if;
	logic                 start;
	lssr_pkg::lssr_speed_t phy_speed;
	lssr_pkg::lssr_speed_t result;
	logic                 done;
	modport ctl (output start, output phy_speed, input result, input done);
	modport det (input start, input phy_speed, output result, output done);
endinterface : lssr_det_if

// *** core/lssr_pkg.sv ***
package lssr_pkg;
	typedef logic [1:0] lssr_speed_t;
	typedef enum logic [2:0]
	{
		DET_IDLE  = 3'b001,
		DET_SENSE = 3'b010,
		DET_DONE  = 3'b100
	} lssr_det_e;
endpackage : lssr_pkg

// *** core/lssr_top.sv ***
`timescale 1ns/100ps
`include "lssr_defines.svh"
// Functional notes
// - Speed code: 00 10M, 01 100M, 1x 1000M.
// - Speed from force, else auto, else PHY.
// - Auto speed set once per link up.
// - Speed field invalid in SerDes mode.
// - Bits 9:8 show auto-detected speed.
// - Trigger write starts detection, stores result.
// - PHY reset sets bit 10; resets to one.
// - Bit 10 clears only on zero write.
// - Bit 19 clears when disabled and idle.
// - No new requests while stopped and disabled.
module lssr_top (
	input  wire logic                  aclk,
	input  wire logic                  aresetn,
	input  wire logic [7:0]            awaddr,
	input  wire logic                  awvalid,
	output logic                       awready,
	input  wire logic [31:0]           wdata,
	input  wire logic [3:0]            wstrb,
	input  wire logic                  wvalid,
	output logic                       wready,
	output logic [1:0]                 bresp,
	output logic                       bvalid,
	input  wire logic                  bready,
	input  wire logic [7:0]            araddr,
	input  wire logic                  arvalid,
	output logic                       arready,
	output logic [31:0]                rdata,
	output logic [1:0]                 rresp,
	output logic                       rvalid,
	input  wire logic                  rready,
	input  wire lssr_pkg::lssr_speed_t phy_speed_pin,
	input  wire logic                  phy_reset_pin,
	input  wire logic                  link_up_pin,
	input  wire logic                  serdes_mode,
	input  wire logic                  master_pending,
	input  wire logic                  master_req_in,
	output logic                       master_req_out,
	output lssr_pkg::lssr_speed_t      link_speed,
	output logic                       irq
);
	import lssr_pkg::*;

	lssr_det_if dif ();
	lssr_spd_det u_det (.aclk(aclk), .aresetn(aresetn), .dif(dif));

	// Pin synchronisers; only the second stage feeds any logic.
	logic [3:0] sync1;
	logic [3:0] sync2;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync1 <= 4'h0;
			sync2 <= 4'h0;
		end
		else
		begin
			sync1 <= {link_up_pin, phy_reset_pin, phy_speed_pin};
			sync2 <= sync1;
		end
	end
	lssr_speed_t phy_speed_s;
	logic        phyr_s;
	logic        link_s;
	assign phy_speed_s   = sync2[1:0];
	assign phyr_s        = sync2[2];
	assign link_s        = sync2[3];
	assign dif.phy_speed = phy_speed_s;

	// Bus state.
	logic              aw_hold, next_aw_hold, w_hold, next_w_hold;
	logic [7:0]        aw_q, next_aw_q;
	logic [31:0]       wd_q, next_wd_q;
	logic [3:0]        ws_q, next_ws_q;
	logic              next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
	logic [1:0]        next_bresp, next_rresp;
	logic [31:0]       next_rdata;
	logic              wr_go;

	// Block state.
	logic [1:0]        ctl_fspd, next_ctl_fspd;
	logic              ctl_frc, next_ctl_frc, ctl_auto, next_ctl_auto;
	logic              ctl_mdis, next_ctl_mdis;
	logic              phy_reset_flag, next_phy_reset_flag;
	logic              master_active_flag, next_master_active_flag;
	lssr_speed_t       sensed_speed_value, next_sensed_speed_value;
	lssr_speed_t       speed_cfg, next_speed_cfg;
	logic              cfg_locked, next_cfg_locked;
	logic              link_q, phyr_q, det_start, next_det_start;
	logic [`LSSR_IRQ_W-1:0] istat, next_istat, imask, next_imask;
	logic [`LSSR_IRQ_W-1:0] events;
	lssr_speed_t       next_link_speed;
	logic              next_irq, next_req_out;
	logic              phyr_rise, link_rise, trig_wr, status_wr;

	assign dif.start = det_start;
	assign wr_go     = aw_hold && w_hold && !bvalid;
	assign status_wr = wr_go && (aw_q == `LSSR_OFS_STATUS);
	assign trig_wr   = wr_go && (aw_q == `LSSR_OFS_CTRL) && ws_q[0] && wd_q[`LSSR_C_TRIG_BIT];
	assign phyr_rise = phyr_s && !phyr_q;
	assign link_rise = link_s && !link_q;

	function automatic logic [31:0] read_word(input logic [7:0] a);
		logic [31:0] v;
		v = 32'h0;
		unique case (a)
			`LSSR_OFS_STATUS:
			begin
				v[`LSSR_SPD_LSB +: 2]  = link_speed;
				v[`LSSR_SENSED_LSB +: 2] = sensed_speed_value;
				v[`LSSR_PHYR_FLAG_BIT]   = phy_reset_flag;
				v[`LSSR_MACT_BIT]      = master_active_flag;
			end
			`LSSR_OFS_CTRL:
			begin
				v[`LSSR_C_FSPD_LSB +: 2] = ctl_fspd;
				v[`LSSR_C_FRC_BIT]       = ctl_frc;
				v[`LSSR_C_AUTO_BIT]      = ctl_auto;
				v[`LSSR_C_MDIS_BIT]      = ctl_mdis;
			end
			`LSSR_OFS_ISTAT: v[`LSSR_IRQ_W-1:0] = istat;
			`LSSR_OFS_IMASK: v[`LSSR_IRQ_W-1:0] = imask;
			default:         v = 32'h0;
		endcase
		return v;
	endfunction : read_word

	function automatic logic mapped(input logic [7:0] a);
		return (a == `LSSR_OFS_STATUS) || (a == `LSSR_OFS_CTRL) ||
			(a == `LSSR_OFS_ISTAT) || (a == `LSSR_OFS_IMASK);
	endfunction : mapped

	always_comb
	begin
		next_aw_hold = aw_hold;
		next_aw_q    = aw_q;
		next_w_hold  = w_hold;
		next_wd_q    = wd_q;
		next_ws_q    = ws_q;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		if (bvalid && bready)
			next_bvalid = 1'b0;
		if (awvalid && awready)
		begin
			next_aw_hold = 1'b1;
			next_aw_q    = {awaddr[7:2], 2'h0};
		end
		if (wvalid && wready)
		begin
			next_w_hold = 1'b1;
			next_wd_q   = wdata;
			next_ws_q   = wstrb;
		end
		if (wr_go)
		begin
			next_aw_hold = 1'b0;
			next_w_hold  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = mapped(aw_q) ? `LSSR_RESP_OKAY : `LSSR_RESP_SLVERR;
		end
		if (rvalid && rready)
			next_rvalid = 1'b0;
		if (arvalid && arready)
		begin
			next_rvalid = 1'b1;
			next_rdata  = read_word({araddr[7:2], 2'h0});
			next_rresp  = mapped({araddr[7:2], 2'h0}) ? `LSSR_RESP_OKAY : `LSSR_RESP_SLVERR;
		end
		next_awready = !next_aw_hold && !next_bvalid;
		next_wready  = !next_w_hold && !next_bvalid;
		next_arready = !next_rvalid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold <= 1'b0;
			aw_q    <= 8'h00;
			w_hold  <= 1'b0;
			wd_q    <= 32'h0;
			ws_q    <= 4'h0;
			awready <= 1'b0;
			wready  <= 1'b0;
			bvalid  <= 1'b0;
			bresp   <= `LSSR_RESP_OKAY;
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h0;
			rresp   <= `LSSR_RESP_OKAY;
		end
		else
		begin
			aw_hold <= next_aw_hold;
			aw_q    <= next_aw_q;
			w_hold  <= next_w_hold;
			wd_q    <= next_wd_q;
			ws_q    <= next_ws_q;
			awready <= next_awready;
			wready  <= next_wready;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			arready <= next_arready;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
		end
	end

	always_comb
	begin
		next_ctl_fspd           = ctl_fspd;
		next_ctl_frc            = ctl_frc;
		next_ctl_auto           = ctl_auto;
		next_ctl_mdis           = ctl_mdis;
		next_istat              = istat;
		next_imask              = imask;
		next_phy_reset_flag     = phy_reset_flag;
		next_sensed_speed_value = sensed_speed_value;
		next_speed_cfg          = speed_cfg;
		next_cfg_locked         = cfg_locked;
		if (wr_go && ws_q[0] && (aw_q == `LSSR_OFS_CTRL))
		begin
			next_ctl_fspd = wd_q[`LSSR_C_FSPD_LSB +: 2];
			next_ctl_frc  = wd_q[`LSSR_C_FRC_BIT];
			next_ctl_auto = wd_q[`LSSR_C_AUTO_BIT];
			next_ctl_mdis = wd_q[`LSSR_C_MDIS_BIT];
		end
		if (wr_go && ws_q[0] && (aw_q == `LSSR_OFS_IMASK))
			next_imask = wd_q[`LSSR_IRQ_W-1:0];
		if (wr_go && ws_q[0] && (aw_q == `LSSR_OFS_ISTAT))
			next_istat = istat & ~wd_q[`LSSR_IRQ_W-1:0];
		if (status_wr && ws_q[1] && !wd_q[`LSSR_PHYR_FLAG_BIT])
			next_phy_reset_flag = 1'b0;
		if (phyr_rise)
			next_phy_reset_flag = 1'b1;
		if (dif.done)
			next_sensed_speed_value = dif.result;
		if (!link_s)
			next_cfg_locked = 1'b0;
		else if (ctl_auto && !cfg_locked && dif.done)
		begin
			next_speed_cfg  = dif.result;
			next_cfg_locked = 1'b1;
		end
		next_det_start = trig_wr || (ctl_auto && link_rise);
		next_master_active_flag = !(ctl_mdis && !master_pending);
		next_req_out = master_req_in && next_master_active_flag;
		if (serdes_mode)
			next_link_speed = `LSSR_SPD_10;
		else if (ctl_frc)
			next_link_speed = ctl_fspd;
		else if (ctl_auto)
			next_link_speed = speed_cfg;
		else
			next_link_speed = phy_speed_s;
		events = '0;
		events[`LSSR_I_PHYR]  = phyr_rise;
		events[`LSSR_I_DET]   = dif.done;
		events[`LSSR_I_MSTOP] = master_active_flag && !next_master_active_flag;
		next_istat = next_istat | events;
		next_irq   = |(next_istat & next_imask);
	end

	// Status writes touch only the clear of bit 10; read-only fields have no write path.
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			ctl_fspd           <= `LSSR_SPD_10;
			ctl_frc            <= 1'b0;
			ctl_auto           <= 1'b0;
			ctl_mdis           <= 1'b0;
			istat              <= '0;
			imask              <= '0;
			phy_reset_flag     <= `LSSR_PHYR_FLAG_RST;
			master_active_flag <= `LSSR_MACT_RST;
			sensed_speed_value <= `LSSR_SPD_10;
			speed_cfg          <= `LSSR_SPD_10;
			cfg_locked         <= 1'b0;
			link_q             <= 1'b0;
			phyr_q             <= 1'b0;
			det_start          <= 1'b0;
			master_req_out     <= 1'b0;
			link_speed         <= `LSSR_SPD_10;
			irq                <= 1'b0;
		end
		else
		begin
			ctl_fspd           <= next_ctl_fspd;
			ctl_frc            <= next_ctl_frc;
			ctl_auto           <= next_ctl_auto;
			ctl_mdis           <= next_ctl_mdis;
			istat              <= next_istat;
			imask              <= next_imask;
			phy_reset_flag     <= next_phy_reset_flag;
			master_active_flag <= next_master_active_flag;
			sensed_speed_value <= next_sensed_speed_value;
			speed_cfg          <= next_speed_cfg;
			cfg_locked         <= next_cfg_locked;
			link_q             <= link_s;
			phyr_q             <= phyr_s;
			det_start          <= next_det_start;
			master_req_out     <= next_req_out;
			link_speed         <= next_link_speed;
			irq                <= next_irq;
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	a_spd_force: assert property ((ctl_frc && !serdes_mode) |=> link_speed == $past(ctl_fspd))
		else $error("forced speed not shown");
	a_spd_phy: assert property ((!ctl_frc && !ctl_auto && !serdes_mode) |=> link_speed == $past(phy_speed_s))
		else $error("phy speed not shown");
	a_spd_serdes: assert property (serdes_mode |=> link_speed == `LSSR_SPD_10)
		else $error("speed field not neutral in serdes mode");
	a_auto_hold: assert property ((cfg_locked && link_s) |=> speed_cfg == $past(speed_cfg))
		else $error("speed changed while link up");
	a_sensed_speed_value_update: assert property (dif.done |=> sensed_speed_value == $past(dif.result))
		else $error("sensed speed not stored");
	a_trig_run: assert property (trig_wr |=> det_start ##[1:2] u_det.state == DET_SENSE)
		else $error("trigger did not start detection");
	a_phyr_set: assert property (phyr_rise |=> phy_reset_flag)
		else $error("phy reset flag not set");
	a_phyr_keep: assert property ((phy_reset_flag && !(status_wr && ws_q[1] && !wd_q[`LSSR_PHYR_FLAG_BIT]))
		|=> phy_reset_flag)
		else $error("phy reset flag cleared without zero write");
	a_mact_clr: assert property ((ctl_mdis && !master_pending) |=> !master_active_flag)
		else $error("master active not cleared");
	a_mreq_block: assert property (!master_active_flag |-> !master_req_out)
		else $error("request issued while stopped");
	a_rsvd_zero: assert property (rvalid |-> rdata[31:20] == 12'h000)
		else $error("reserved bits not zero");
	a_ro_ignore: assert property ((status_wr && !dif.done) |=> $stable(sensed_speed_value))
		else $error("write changed read-only field");

	c_write: cover property (bvalid && bready && bresp == `LSSR_RESP_OKAY);
	c_read: cover property (rvalid && rready && rresp == `LSSR_RESP_OKAY);
	c_auto_lock: cover property (!cfg_locked ##1 cfg_locked);
	c_mstop: cover property (master_active_flag ##1 !master_active_flag ##1 irq);
endmodule : lssr_top

// *** testbench/lssr_top_tb.sv ***
`timescale 1ns/100ps
`include "lssr_defines.svh"
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_errors++; \
	$display("[FAIL] %s exp %h got %h", nm, e, g); end end

module lssr_top_tb;
	import lssr_pkg::*;
	logic        aclk = 1'b0;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'h0;
	logic        awready, wready, bvalid, arready, rvalid, master_req_out, irq;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	lssr_speed_t phy_speed_pin = 2'h1;
	lssr_speed_t link_speed;
	logic        phy_reset_pin = 1'b0, link_up_pin = 1'b0, serdes_mode = 1'b0;
	logic        master_pending = 1'b1, master_req_in = 1'b0;
	logic [33:0] exp_r[$];
	logic [1:0]  exp_b[$];
	logic [33:0] r_note;
	int          n_errors = 0, n_tests = 0, cyc = 0;
	lssr_speed_t f;

	lssr_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.phy_speed_pin(phy_speed_pin), .phy_reset_pin(phy_reset_pin),
		.link_up_pin(link_up_pin), .serdes_mode(serdes_mode),
		.master_pending(master_pending), .master_req_in(master_req_in),
		.master_req_out(master_req_out), .link_speed(link_speed), .irq(irq));

	always #5 aclk = ~aclk;

	task automatic give_verdict;
		if (n_errors == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : give_verdict

	// A hang in any handshake ends the run as a failure.
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_errors++;
			give_verdict();
		end
	end

	// Results are compared in the order they were noted.
	always @(posedge aclk)
	begin
		if (rvalid && rready)
		begin
			r_note = (exp_r.size() > 0) ? exp_r.pop_front() : 34'h3FFFFFFFF;
			`CHK("rdata", r_note[31:0], rdata)
			`CHK("rresp", r_note[33:32], rresp)
		end
		if (bvalid && bready)
		begin
			`CHK("bresp", ((exp_b.size() > 0) ? exp_b.pop_front() : 2'h1), bresp)
		end
	end

	function automatic logic [31:0] st(lssr_speed_t s, lssr_speed_t a, logic p, logic m);
		st = {12'h0, m, 8'h0, p, a, s, 6'h0};
	endfunction : st

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		bit done;
		exp_b.push_back(r);
		@(posedge aclk);
		awaddr  <= a;
		awvalid <= 1'b1;
		wdata   <= d;
		wstrb   <= s;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		done = 0;
		while (!done)
		begin
			@(posedge aclk);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid)
			begin
				bready <= 1'b0;
				done = 1;
			end
		end
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		bit done;
		exp_r.push_back({r, d});
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		done = 0;
		while (!done)
		begin
			@(posedge aclk);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid)
			begin
				rready <= 1'b0;
				done = 1;
			end
		end
	endtask : rd

	task automatic pause(input int n);
		repeat (n) @(posedge aclk);
	endtask : pause

	localparam logic [7:0] ST = `LSSR_OFS_STATUS, CT = `LSSR_OFS_CTRL;
	localparam logic [7:0] IS = `LSSR_OFS_ISTAT, IM = `LSSR_OFS_IMASK;
	localparam logic [1:0] OK = `LSSR_RESP_OKAY;

	initial
	begin
		void'($urandom(32'h0e82b7ed));
		pause(2);
		aresetn <= 1'b1;
		pause(4);
		rd(ST, st(2'h1, 2'h0, 1'b1, 1'b1), OK);
		for (int c = 0; c < 4; c++)
		begin
			phy_speed_pin <= 2'(c);
			pause(5);
			rd(ST, st(2'(c), 2'h0, 1'b1, 1'b1), OK);
			`CHK("link_speed", 2'(c), link_speed)
		end
		f = 2'($urandom);
		wr(CT, 32'(f) | 32'h4, 4'h1, OK);
		rd(ST, st(f, 2'h0, 1'b1, 1'b1), OK);
		wr(CT, 32'h0, 4'h1, OK);
		// Ones in every bit but 18:11 must leave the flag set and read-only fields alone.
		wr(ST, 32'hFFF807FF, 4'hF, OK);
		rd(ST, st(2'h3, 2'h0, 1'b1, 1'b1), OK);
		wr(ST, 32'h0, 4'h2, OK);
		rd(ST, st(2'h3, 2'h0, 1'b0, 1'b1), OK);
		phy_reset_pin <= 1'b1;
		pause(6);
		phy_reset_pin <= 1'b0;
		`CHK("irq masked", 1'b0, irq)
		rd(ST, st(2'h3, 2'h0, 1'b1, 1'b1), OK);
		wr(IM, 32'h7, 4'h1, OK);
		pause(2);
		`CHK("irq", 1'b1, irq)
		wr(IS, 32'h1, 4'h1, OK);
		pause(2);
		`CHK("irq clear", 1'b0, irq)
		phy_speed_pin <= 2'h2;
		wr(CT, 32'h20, 4'h1, OK);
		pause(20);
		rd(ST, st(2'h2, 2'h2, 1'b1, 1'b1), OK);
		rd(IS, 32'h2, OK);
		wr(IS, 32'h7, 4'h1, OK);
		// Auto speed is taken once per link up and then held.
		wr(CT, 32'h8, 4'h1, OK);
		phy_speed_pin <= 2'h1;
		link_up_pin <= 1'b1;
		pause(20);
		rd(ST, st(2'h1, 2'h1, 1'b1, 1'b1), OK);
		phy_speed_pin <= 2'h0;
		wr(CT, 32'h28, 4'h1, OK);
		pause(20);
		rd(ST, st(2'h1, 2'h0, 1'b1, 1'b1), OK);
		link_up_pin <= 1'b0;
		wr(CT, 32'h0, 4'h1, OK);
		wr(IS, 32'h7, 4'h1, OK);
		phy_speed_pin <= 2'h3;
		serdes_mode <= 1'b1;
		pause(5);
		rd(ST, st(2'h0, 2'h0, 1'b1, 1'b1), OK);
		serdes_mode <= 1'b0;
		master_req_in <= 1'b1;
		wr(CT, 32'h10, 4'h1, OK);
		pause(3);
		`CHK("req pending", 1'b1, master_req_out)
		rd(ST, st(2'h3, 2'h0, 1'b1, 1'b1), OK);
		master_pending <= 1'b0;
		pause(3);
		`CHK("req stopped", 1'b0, master_req_out)
		rd(ST, st(2'h3, 2'h0, 1'b1, 1'b0), OK);
		rd(IS, 32'h4, OK);
		wr(CT, 32'h0, 4'h1, OK);
		pause(3);
		`CHK("req resumed", 1'b1, master_req_out)
		rd(ST, st(2'h3, 2'h0, 1'b1, 1'b1), OK);
		rd(8'h10, 32'h0, `LSSR_RESP_SLVERR);
		wr(8'h10, 32'hFFFFFFFF, 4'hF, `LSSR_RESP_SLVERR);
		pause(3);
		give_verdict();
	end
endmodule : lssr_top_tb
